// >>> core/prog_bus_ctrl.v
// External program-memory bus control: fetch routing, multiplexed port zero, strobes.
`include "prog_bus_regs.vh"
module prog_bus_ctrl (
  input  wire        CLK_SYS,
  input  wire        RESET_N,
  input  wire        EXTERNAL_FETCH_SELECT_N,
  input  wire        RESET_PIN,
  input  wire        FETCH_REQ,
  input  wire        CODE_TABLE_READ,
  input  wire [15:0] FETCH_ADDR,
  input  wire [7:0]  INT_ROM_DATA,
  output wire        FETCH_READY,
  output reg  [7:0]  FETCH_DATA,
  output reg         FETCH_VALID,
  output reg         FETCH_EXTERNAL,
  output wire        CORE_RESET,
  input  wire [7:0]  PORT_ZERO_BUS_IN,
  output reg  [7:0]  PORT_ZERO_BUS_OUT,
  output reg  [7:0]  PORT_ZERO_BUS_OE_N,
  output reg  [7:0]  PORT_TWO_BUS_OUT,
  output reg         ADDR_LATCH_STROBE,
  output reg         PROGRAM_FETCH_STROBE_N
);
  reg  [4:0] state_r;
  reg  [4:0] state_nxt;
  reg  [1:0] phase_r;
  reg  [7:0] p0_meta_r;
  reg  [7:0] p0_sync_r;
  reg  [1:0] sel_sync_r;
  reg  [1:0] rst_sync_r;
  reg  [1:0] wait_r;
  reg  [1:0] wait_nxt;
  reg  [7:0] addr_lo_r;
  reg  [7:0] addr_lo_nxt;
  reg        drive_lo_r;
  reg        drive_lo_nxt;
  reg  [7:0] data_nxt;
  reg        valid_nxt;
  reg        external_nxt;
  reg  [7:0] port_two_nxt;
  reg        latch_nxt;
  reg        strobe_n_nxt;
  wire       mc_tick;
  wire       go_external;
  wire       bus_reset;
  wire       take;
  wire [7:0] oe_n_nxt;
  wire [7:0] port_zero_nxt;

  assign mc_tick   = (phase_r == `CLKS_PER_MC - 3'h1);
  assign bus_reset = !RESET_N || CORE_RESET;
  // Select input is low-active on the pin; above 32 KB is always external.
  assign go_external = !sel_sync_r[1] || FETCH_ADDR[`INT_ROM_TOP_BIT];
  assign FETCH_READY = (state_r == `ST_IDLE) && !CORE_RESET;
  assign take        = FETCH_REQ && FETCH_READY;

  always @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      phase_r    <= 2'h0;
      p0_meta_r  <= 8'hFF;
      p0_sync_r  <= 8'hFF;
      sel_sync_r <= 2'h3;
      rst_sync_r <= 2'h0;
    end else begin
      phase_r    <= phase_r + 2'h1;
      p0_meta_r  <= PORT_ZERO_BUS_IN;
      p0_sync_r  <= p0_meta_r;
      sel_sync_r <= {sel_sync_r[0], EXTERNAL_FETCH_SELECT_N};
      rst_sync_r <= {rst_sync_r[0], RESET_PIN};
    end
  end

  reset_qualifier u_rstq (
    .clk        (CLK_SYS),
    .reset_n    (RESET_N),
    .mc_tick    (mc_tick),
    .pin_sync   (rst_sync_r[1]),
    .core_rst_r (CORE_RESET)
  );

  // Port zero is open drain: a line is pulled only for a zero address bit,
  // and a one is left to the pull-up. While released every enable is high.
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_p0_drive
      assign oe_n_nxt[b]      = drive_lo_nxt ? addr_lo_nxt[b] : 1'b1;
      assign port_zero_nxt[b] = drive_lo_nxt ? addr_lo_nxt[b] : 1'b1;
    end
  endgenerate

  // Next-state logic of one access. An external access runs:
  // take, latch pulse with the low address out, latch low with the address
  // still out, then the strobe with the port released, then the data sample.
  // The strobe is held low long enough for the returned byte to cross the
  // two-stage port sampler; a shorter strobe would read the address back.
  always @* begin
    state_nxt    = state_r;
    wait_nxt     = wait_r;
    addr_lo_nxt  = addr_lo_r;
    drive_lo_nxt = drive_lo_r;
    data_nxt     = FETCH_DATA;
    valid_nxt    = 1'b0;
    external_nxt = FETCH_EXTERNAL;
    port_two_nxt = PORT_TWO_BUS_OUT;
    latch_nxt    = 1'b0;
    strobe_n_nxt = 1'b1;
    case (state_r)
      `ST_IDLE: begin
        if (take) begin
          if (go_external) begin
            state_nxt    = `ST_ADDR;
            external_nxt = 1'b1;
            addr_lo_nxt  = FETCH_ADDR[7:0];
            drive_lo_nxt = 1'b1;
            port_two_nxt = FETCH_ADDR[15:8];
            latch_nxt    = 1'b1;
          end else begin
            // Internal code never touches the pins, so no strobe either.
            data_nxt     = INT_ROM_DATA;
            valid_nxt    = 1'b1;
            external_nxt = 1'b0;
          end
        end
      end
      `ST_ADDR: begin
        // Latch strobe is high in this state and falls next while the address still stands.
        state_nxt = `ST_LATCH;
      end
      `ST_LATCH: begin
        drive_lo_nxt = 1'b0;
        strobe_n_nxt = 1'b0;
        wait_nxt     = `STROBE_WAIT;
        state_nxt    = `ST_STROBE;
      end
      `ST_STROBE: begin
        if (wait_r != 2'h0) begin
          strobe_n_nxt = 1'b0;
          wait_nxt     = wait_r - 2'h1;
        end else begin
          data_nxt  = p0_sync_r;
          state_nxt = `ST_DONE;
        end
      end
      `ST_DONE: begin
        valid_nxt = 1'b1;
        state_nxt = `ST_IDLE;
      end
      default: begin
        state_nxt = `ST_IDLE;
      end
    endcase
  end

  // Registers of the access. Both resets return the pins to the released
  // level so that a cut access leaves nothing driven on the bus.
  always @(posedge CLK_SYS) begin
    if (bus_reset) begin
      state_r                <= `ST_IDLE;
      wait_r                 <= 2'h0;
      addr_lo_r              <= 8'h00;
      drive_lo_r             <= 1'b0;
      FETCH_DATA             <= 8'h00;
      FETCH_VALID            <= 1'b0;
      FETCH_EXTERNAL         <= 1'b0;
      PORT_ZERO_BUS_OUT      <= 8'hFF;
      PORT_ZERO_BUS_OE_N     <= 8'hFF;
      PORT_TWO_BUS_OUT       <= 8'hFF;
      ADDR_LATCH_STROBE      <= 1'b0;
      PROGRAM_FETCH_STROBE_N <= 1'b1;
    end else begin
      state_r                <= state_nxt;
      wait_r                 <= wait_nxt;
      addr_lo_r              <= addr_lo_nxt;
      drive_lo_r             <= drive_lo_nxt;
      FETCH_DATA             <= data_nxt;
      FETCH_VALID            <= valid_nxt;
      FETCH_EXTERNAL         <= external_nxt;
      PORT_ZERO_BUS_OUT      <= port_zero_nxt;
      PORT_ZERO_BUS_OE_N     <= oe_n_nxt;
      PORT_TWO_BUS_OUT       <= port_two_nxt;
      ADDR_LATCH_STROBE      <= latch_nxt;
      PROGRAM_FETCH_STROBE_N <= strobe_n_nxt;
    end
  end
endmodule

// >>> core/reset_qualifier.v
// Reset pin filter: asserts a reset once the high level has been seen at two successive machine-cycle ticks.
`include "prog_bus_regs.vh"
module reset_qualifier (
  input  wire clk,
  input  wire reset_n,
  input  wire mc_tick,
  input  wire pin_sync,
  output reg  core_rst_r
);
  reg [1:0] held_r;

  always @(posedge clk) begin
    if (!reset_n) begin
      held_r     <= 2'h0;
      core_rst_r <= 1'b0;
    end else if (!pin_sync) begin
      held_r     <= 2'h0;
      core_rst_r <= 1'b0;
    end else if (mc_tick) begin
      if (held_r == `RESET_HOLD_MC - 2'h1) begin
        core_rst_r <= 1'b1;
      end else begin
        held_r <= held_r + 2'h1;
      end
    end
  end
endmodule

// >>> inc/prog_bus_regs.vh
// Timing counts and address limits of the external program bus block.
`ifndef PROG_BUS_REGS_VH
`define PROG_BUS_REGS_VH
`define CLKS_PER_MC        3'h4
`define RESET_HOLD_MC      2'h2
`define INT_ROM_TOP_BIT    15
`define STROBE_WAIT        2'h2
`define ST_IDLE            5'h01
`define ST_ADDR            5'h02
`define ST_LATCH           5'h04
`define ST_STROBE          5'h08
`define ST_DONE            5'h10
`endif

// >>> sim/ext_rom_model.sv
// External program ROM behind an address latch, with pull-ups on port zero.
module ext_rom_model (
  input  wire       clk,
  input  wire       ale,
  input  wire       stb_n,
  input  wire [7:0] oe_n,
  input  wire [7:0] hi,
  output wire [7:0] pin
);
  timeunit 1ns / 1ns;
  reg [7:0] lo_r;
  reg [1:0] hold_r = 2'h0;
  // Data is held two cycles past the strobe because the port sampler lags.
  assign pin = oe_n & (stb_n && hold_r == 2'h0 ? 8'hFF : lo_r ^ hi ^ 8'hA5);
  always @(posedge clk) begin
    if (ale) lo_r <= pin;
    hold_r <= stb_n ? hold_r - {1'b0, |hold_r} : 2'h2;
  end
endmodule

// >>> sim/prog_bus_properties.sv
// Port timing checks for the program bus controller.
module prog_bus_properties (
  input wire CLK_SYS, RESET_N, EXTERNAL_FETCH_SELECT_N, FETCH_REQ, FETCH_READY,
  input wire FETCH_VALID, CORE_RESET, ADDR_LATCH_STROBE, PROGRAM_FETCH_STROBE_N,
  input wire FETCH_EXTERNAL,
  input wire [15:0] FETCH_ADDR,
  input wire [7:0]  PORT_ZERO_BUS_OE_N, PORT_TWO_BUS_OUT
);
  timeunit 1ns / 1ns;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  wire       tk = FETCH_REQ && FETCH_READY;
  wire       al = ADDR_LATCH_STROBE;
  wire       st = PROGRAM_FETCH_STROBE_N;
  wire       ah = FETCH_ADDR[15];
  wire [7:0] hi = FETCH_ADDR[15:8];
  reg  [3:0] sel_r;
  always @(posedge CLK_SYS) sel_r <= {sel_r[2:0], EXTERNAL_FETCH_SELECT_N};
  a_latch_off: assert property (al |-> st) else $error("latch");
  a_latch_seq: assert property ($rose(al) |-> ##2 !st[*3] ##1 st) else $error("seq");
  a_ext_time: assert property (tk && ah |=> al ##6 FETCH_VALID) else $error("ext");
  a_ext_flag: assert property (tk && ah |=> FETCH_EXTERNAL) else $error("flag");
  a_sel_ext: assert property (tk && sel_r == 4'h0 |=> al) else $error("sel");
  a_int_quiet: assert property (tk && !ah && &sel_r |=> FETCH_VALID && st && !al)
    else $error("int");
  a_p2_high: assert property ($rose(al) |-> PORT_TWO_BUS_OUT == $past(hi)) else $error("p2");
  a_p0_free: assert property (!st |-> PORT_ZERO_BUS_OE_N == 8'hFF) else $error("p0");
  a_core_idle: assert property (CORE_RESET |-> !FETCH_READY ##1 (!al && st)) else $error("rst");
endmodule

// >>> sim/testbench.sv
// Bench: fetches through the program bus controller into an external ROM model.
module testbench;
  timeunit 1ns / 1ns;
  reg        clk = 1'b0, rn = 1'b0, sn = 1'b1, rp = 1'b0, rq = 1'b0, ct = 1'b0;
  reg [15:0] a = 16'h0000;
  wire       rdy, vl, cr, al, st;
  wire [7:0] d, p0, oe, p2;
  integer    errors = 0, tests_run = 0, seed = 73, n, i;
  reg [7:0]  q[$];
  prog_bus_ctrl DUT (.CLK_SYS(clk), .RESET_N(rn), .EXTERNAL_FETCH_SELECT_N(sn), .RESET_PIN(rp),
    .FETCH_REQ(rq), .CODE_TABLE_READ(ct), .FETCH_ADDR(a), .INT_ROM_DATA(~a[7:0]),
    .FETCH_READY(rdy), .FETCH_DATA(d), .FETCH_VALID(vl), .FETCH_EXTERNAL(), .CORE_RESET(cr),
    .PORT_ZERO_BUS_IN(p0), .PORT_ZERO_BUS_OUT(), .PORT_ZERO_BUS_OE_N(oe),
    .PORT_TWO_BUS_OUT(p2), .ADDR_LATCH_STROBE(al), .PROGRAM_FETCH_STROBE_N(st));
  ext_rom_model rom (.clk(clk), .ale(al), .stb_n(st), .oe_n(oe), .hi(p2), .pin(p0));
  initial forever #10 clk = ~clk;
  task chk(input [7:0] g, input [7:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  always @(posedge clk) if (vl === 1'b1) chk(d, q.pop_front());
  // Internal fetches keep the request up so they run back to back.
  task fetch(input [15:0] x);
    for (i = 0; i < 20 && rdy !== 1'b1; i = i + 1) @(posedge clk) #2;
    a = x;
    rq = 1'b1;
    ct = $random(seed);
    q.push_back(x[15] || !sn ? x[7:0] ^ x[15:8] ^ 8'hA5 : ~x[7:0]);
    @(posedge clk) #2;
    if (x[15] || !sn) rq = 1'b0;
  endtask
  task close_out;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (1000) @(posedge clk);
    errors = errors + 1;
    close_out;
  end
  initial begin
    repeat (12) @(posedge clk) #2;
    rn = 1'b1;
    for (n = 0; n < 24; n = n + 1) fetch($random(seed) & 16'h7FFF | {n[2], 15'h0000});
    rq = 1'b0;
    $display("fetch test done");
    sn = 1'b0;
    repeat (5) @(posedge clk) #2;
    for (n = 0; n < 4; n = n + 1) fetch($random(seed) & 16'h7FFF);
    sn = 1'b1;
    rp = 1'b1;
    repeat (20) @(posedge clk) #2;
    chk(cr, 8'h01);
    rp = 1'b0;
    repeat (4) @(posedge clk) #2;
    chk(cr, 8'h00);
    fetch(16'hFF00);
    repeat (8) @(posedge clk) #2;
    $display("reset test done");
    close_out;
  end
endmodule
bind prog_bus_ctrl prog_bus_properties props (.*);
